// file: dpt_dev_model.sv
// Behavioural dual-port device as seen from the left port
`timescale 1ns/1ps
module dpt_dev_model
  import dpt_pkg::*;
(
  // Clock used only to sample settled pin levels
  input  logic              sys_clk,
  // Left port controls from the controller
  input  logic              ce_n,
  input  logic              rw_n,
  input  logic              oe_n,
  input  logic              token_select_n,
  input  logic              upper_lane_select_n,
  input  logic              lower_lane_select_n,
  input  logic [ADDR_W-1:0] mem_addr,
  // Data bus, resolved here
  input  logic [DATA_W-1:0] data_out,
  input  logic              data_oe,
  output logic [DATA_W-1:0] data_in,
  // Flags
  input  logic              force_busy,
  output logic              busy_n,
  output logic              int_n,
  output logic              int_r_n
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // Shared array
  logic [1:0]        own [0:7];   // Holder: 0 free, 1 left, 2 right
  logic [7:0]        req [1:2];   // Pending requests per side
  logic              wr_q;        // Write in flight
  logic              hold_q;      // Token read value latched
  logic [DATA_W-1:0] wd_q;        // Last data seen during write
  logic [DATA_W-1:0] tok_q;       // Token output register
  logic [DATA_W-1:0] last_q;      // Previous bus level
  logic [ADDR_W-1:0] wa_q;        // Write address
  logic [2:0]        wm_q;        // Token, upper, lower of the write
  wire tok   = !token_select_n && ce_n;
  wire msel  = !ce_n && token_select_n;
  wire rd    = !oe_n && rw_n;
  wire lview = (own[mem_addr[2:0]] != 2'd1);
  wire [DATA_W-1:0] drv = !rd ? '0 : tok ? '1 : msel ?
    {{8{!upper_lane_select_n}}, {8{!lower_lane_select_n}}} : '0;
  wire [DATA_W-1:0] dq = tok ? (hold_q ? tok_q : {DATA_W{lview}})
                             : mem[mem_addr];
  // Master mode: busy is driven by this device
  assign busy_n = !force_busy;
  // Released lines show the inverse of the last level, never a stale copy
  assign data_in = data_oe ? data_out : (drv & dq) | (~drv & ~last_q);

  // Token write by side p; only bit zero of the data matters
  // Calls from the two sides run one at a time, so one side always wins
  task automatic tok_write(input int i, input logic [1:0] p, input logic v);
    if (!v) begin
      if (own[i] == 2'd0) own[i] = p;
      else if (own[i] != p) req[p][i] = 1'b1;
    end else begin
      if (own[i] == p) begin
        own[i] = req[3-p][i] ? 2'(3 - p) : 2'd0;
        req[3-p][i] = 1'b0;
      end
      req[p][i] = 1'b0;
    end
  endtask

  // Right port writes the left mailbox
  task automatic right_mbox(input logic [DATA_W-1:0] d);
    mem[13'h1FFE] = d;
    int_n = 1'b0;
  endtask

  // All latches free after power-up
  initial begin
    for (int i = 0; i < 8; i++) own[i] = 2'd0;
    req[1] = '0;
    req[2] = '0;
    {int_n, int_r_n, wr_q, hold_q, last_q} = {2'b11, 2'b00, 16'h0000};
  end

  // Sample pins; a write commits when read/write returns high
  always @(posedge sys_clk) begin
    last_q <= data_in;
    hold_q <= tok && rd;
    if (tok && rd && !hold_q) tok_q <= {DATA_W{lview}};
    if (msel && rd && mem_addr == 13'h1FFE && busy_n) int_n <= 1'b1;
    if (!rw_n && (tok || msel) && busy_n) begin
      wr_q <= 1'b1;
      wd_q <= data_in;
      wa_q <= mem_addr;
      wm_q <= {tok, !upper_lane_select_n, !lower_lane_select_n};
    end else if (wr_q && rw_n) begin
      wr_q <= 1'b0;
      if (wm_q[2]) tok_write(int'(wa_q[2:0]), 2'd1, wd_q[0]);
      else begin
        if (wm_q[1]) mem[wa_q][15:8] = wd_q[15:8];
        if (wm_q[0]) mem[wa_q][7:0] = wd_q[7:0];
        if (wa_q == 13'h1FFF) int_r_n <= 1'b0;
      end
    end
  end
endmodule

// file: dpt_host_ctrl.sv
// Host controller driving one port of a dual-port token mailbox memory
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/1ps

module dpt_host_ctrl
  import dpt_pkg::*;
(
  // Clock and reset
  input  logic              sys_clk,
  input  logic              rstn,
  // Software register port
  input  logic [REG_AW-1:0] sw_addr,
  input  logic [31:0]       sw_wdata,
  input  logic              sw_wr,
  input  logic              sw_rd,
  output logic [31:0]       sw_rdata,
  // Memory port controls, all active low, then the address
  output logic              ce_n,
  output logic              rw_n,
  output logic              oe_n,
  output logic              token_select_n,
  output logic              upper_lane_select_n,
  output logic              lower_lane_select_n,
  output logic [ADDR_W-1:0] mem_addr,
  // Memory port data, three-signal form
  input  logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic              data_oe,
  // Flags from the device
  input  logic              busy_n,
  input  logic              int_n
);

  // Sequencer state
  dpt_state_t        state_reg,    state_next;
  logic [CNT_W-1:0]  cnt_reg,      cnt_next;      // Phase countdown
  logic [2:0]        op_reg,       op_next;       // Operation in flight
  logic              phase_wr_reg, phase_wr_next; // Write phase of access
  logic              abort_reg,    abort_next;    // Stop polling request
  // Software visible state
  logic [ADDR_W-1:0] addr_sw_reg,  addr_sw_next;
  logic [DATA_W-1:0] wdata_reg,    wdata_next;
  logic [DATA_W-1:0] rdata_reg,    rdata_next;
  logic [1:0]        lanes_reg,    lanes_next;    // Upper, lower enables
  logic              owned_reg,    owned_next;    // Last token read zero
  logic              cont_reg,     cont_next;     // Sticky contention seen
  logic [31:0]       sw_rdata_reg, sw_rdata_next;
  // Pin registers
  logic              ce_n_reg,     ce_n_next;
  logic              rw_n_reg,     rw_n_next;
  logic              oe_n_reg,     oe_n_next;
  logic              tsel_n_reg,   tsel_n_next;
  logic              ub_n_reg,     ub_n_next;
  logic              lb_n_reg,     lb_n_next;
  logic [ADDR_W-1:0] addr_reg,     addr_next;
  logic [DATA_W-1:0] dout_reg,     dout_next;
  logic              doe_reg,      doe_next;
  // Decode helpers
  logic              ctrl_wr;
  logic              is_token;
  logic              is_acq;
  logic [2:0]        new_op;

  assign ctrl_wr  = sw_wr && (sw_addr == REG_CTRL);
  assign new_op   = sw_wdata[CTRL_OP_MSB:CTRL_OP_LSB];
  assign is_token = (op_reg != OP_MEM_WR) && (op_reg != OP_MEM_RD);
  assign is_acq   = (op_reg == OP_TOK_ACQ);

  // Next-state logic for registers, sequencer and pins
  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    op_next       = op_reg;
    phase_wr_next = phase_wr_reg;
    abort_next    = abort_reg;
    addr_sw_next  = addr_sw_reg;
    wdata_next    = wdata_reg;
    rdata_next    = rdata_reg;
    lanes_next    = lanes_reg;
    owned_next    = owned_reg;
    cont_next     = cont_reg;
    ce_n_next     = ce_n_reg;
    rw_n_next     = rw_n_reg;
    oe_n_next     = oe_n_reg;
    tsel_n_next   = tsel_n_reg;
    ub_n_next     = ub_n_reg;
    lb_n_next     = lb_n_reg;
    addr_next     = addr_reg;
    dout_next     = dout_reg;
    doe_next      = doe_reg;
    sw_rdata_next = 32'h0000_0000;

    // Register writes; address and data are free to change at any time
    if (sw_wr && sw_addr == REG_ADDR) begin
      addr_sw_next = sw_wdata[ADDR_W-1:0];
    end
    if (sw_wr && sw_addr == REG_WDATA) begin
      wdata_next = sw_wdata[DATA_W-1:0];
    end
    if (sw_wr && sw_addr == REG_STATUS && sw_wdata[ST_CONTENTION_BIT]) begin
      cont_next = 1'b0;
    end
    // Abort only matters while a poll loop runs
    if (ctrl_wr && sw_wdata[CTRL_ABORT_BIT] && state_reg != ST_IDLE) begin
      abort_next = 1'b1;
    end

    // Read data appears the cycle after the strobe
    if (sw_rd) begin
      case (sw_addr)
        REG_CTRL:   sw_rdata_next = {26'h0, lanes_reg[0], lanes_reg[1],
                                     1'b0, op_reg};
        REG_ADDR:   sw_rdata_next = {19'h0, addr_sw_reg};
        REG_WDATA:  sw_rdata_next = {16'h0, wdata_reg};
        REG_RDATA:  sw_rdata_next = {16'h0, rdata_reg};
        REG_STATUS: sw_rdata_next = {28'h0, cont_reg, ~int_n, owned_reg,
                                     (state_reg != ST_IDLE)};
        default:    sw_rdata_next = 32'h0000_0000;
      endcase
    end

    case (state_reg)
      // Wait for a start; a start while busy is ignored
      ST_IDLE: begin
        if (ctrl_wr && !sw_wdata[CTRL_ABORT_BIT] && new_op <= OP_TOK_ACQ) begin
          op_next       = new_op;
          abort_next    = 1'b0;
          lanes_next    = {sw_wdata[CTRL_UPPER_BIT], sw_wdata[CTRL_LOWER_BIT]};
          phase_wr_next = (new_op == OP_MEM_WR) || (new_op == OP_TOK_WR) ||
                          (new_op == OP_TOK_ACQ);
          cnt_next      = SETTLE_CYC;
          state_next    = ST_SETUP;
          if (new_op == OP_MEM_WR || new_op == OP_MEM_RD) begin
            // Memory access: lanes as asked, token latches deselected
            ce_n_next   = 1'b0;
            tsel_n_next = 1'b1;
            ub_n_next   = ~sw_wdata[CTRL_UPPER_BIT];
            lb_n_next   = ~sw_wdata[CTRL_LOWER_BIT];
            addr_next   = addr_sw_reg;
          end else begin
            // Token access: chip and lanes off, high address bits zero
            ce_n_next   = 1'b1;
            ub_n_next   = 1'b1;
            lb_n_next   = 1'b1;
            tsel_n_next = 1'b0;
            addr_next   = {{(ADDR_W-TOKEN_AW){1'b0}},
                           addr_sw_reg[TOKEN_AW-1:0]};
          end
        end
      end
      // Address and selects stand while the contention flag settles
      ST_SETUP: begin
        if (cnt_reg != CNT_LAST) begin
          cnt_next = cnt_reg - CNT_LAST;
        end else if (!is_token && !busy_n) begin
          // Lost arbitration: keep waiting, never strobe during contention
          cont_next = 1'b1;
          cnt_next  = SETTLE_CYC;
        end else begin
          cnt_next   = ACCESS_CYC;
          state_next = ST_STROBE;
          if (phase_wr_reg) begin
            rw_n_next = 1'b0;
            doe_next  = 1'b1;
            if (!is_token) begin
              dout_next = wdata_reg;
            end else if (is_acq) begin
              dout_next = DATA_RST;
            end else begin
              dout_next = {{(DATA_W-1){1'b0}}, wdata_reg[0]};
            end
          end else begin
            oe_n_next = 1'b0;
          end
        end
      end
      // Strobe held for the access time, then every select released
      ST_STROBE: begin
        if (cnt_reg != CNT_LAST) begin
          cnt_next = cnt_reg - CNT_LAST;
        end else begin
          if (!phase_wr_reg) begin
            rdata_next = data_in;
            if (is_token) begin
              // Every line carries the token; bit zero is enough
              owned_next = ~data_in[0];
            end
          end
          ce_n_next   = 1'b1;
          rw_n_next   = 1'b1;
          oe_n_next   = 1'b1;
          tsel_n_next = 1'b1;
          ub_n_next   = 1'b1;
          lb_n_next   = 1'b1;
          doe_next    = 1'b0;
          cnt_next    = GAP_CYC;
          state_next  = ST_RECOVER;
        end
      end
      // Deselected gap; acquire loops back into a read of the token
      ST_RECOVER: begin
        if (cnt_reg != CNT_LAST) begin
          cnt_next = cnt_reg - CNT_LAST;
        end else if (is_acq && !abort_reg &&
                     (phase_wr_reg || rdata_reg[0])) begin
          // Read back after the write, or poll again while held elsewhere
          phase_wr_next = 1'b0;
          tsel_n_next   = 1'b0;
          cnt_next      = SETTLE_CYC;
          state_next    = ST_SETUP;
        end else begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // State registers; everything idles deselected after reset
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg    <= ST_IDLE;
      cnt_reg      <= CNT_LAST;
      op_reg       <= OP_MEM_WR;
      phase_wr_reg <= 1'b0;
      abort_reg    <= 1'b0;
      addr_sw_reg  <= ADDR_RST;
      wdata_reg    <= DATA_RST;
      rdata_reg    <= DATA_RST;
      lanes_reg    <= 2'h0;
      owned_reg    <= 1'b0;
      cont_reg     <= 1'b0;
      sw_rdata_reg <= 32'h0000_0000;
      ce_n_reg     <= 1'b1;
      rw_n_reg     <= 1'b1;
      oe_n_reg     <= 1'b1;
      tsel_n_reg   <= 1'b1;
      ub_n_reg     <= 1'b1;
      lb_n_reg     <= 1'b1;
      addr_reg     <= ADDR_RST;
      dout_reg     <= DATA_RST;
      doe_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      op_reg       <= op_next;
      phase_wr_reg <= phase_wr_next;
      abort_reg    <= abort_next;
      addr_sw_reg  <= addr_sw_next;
      wdata_reg    <= wdata_next;
      rdata_reg    <= rdata_next;
      lanes_reg    <= lanes_next;
      owned_reg    <= owned_next;
      cont_reg     <= cont_next;
      sw_rdata_reg <= sw_rdata_next;
      ce_n_reg     <= ce_n_next;
      rw_n_reg     <= rw_n_next;
      oe_n_reg     <= oe_n_next;
      tsel_n_reg   <= tsel_n_next;
      ub_n_reg     <= ub_n_next;
      lb_n_reg     <= lb_n_next;
      addr_reg     <= addr_next;
      dout_reg     <= dout_next;
      doe_reg      <= doe_next;
    end
  end

  // Outputs straight from flip-flops
  assign sw_rdata            = sw_rdata_reg;
  assign ce_n                = ce_n_reg;
  assign rw_n                = rw_n_reg;
  assign oe_n                = oe_n_reg;
  assign token_select_n      = tsel_n_reg;
  assign upper_lane_select_n = ub_n_reg;
  assign lower_lane_select_n = lb_n_reg;
  assign mem_addr            = addr_reg;
  assign data_out            = dout_reg;
  assign data_oe             = doe_reg;

  // Pin discipline checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_write_after_settle: assert property (
    $fell(rw_n_reg) && !ce_n_reg |-> $past(busy_n))
    else $error("memory write started while contention flag low");
  a_settle_time_held: assert property ($fell(ce_n_reg) |-> rw_n_reg[*3])
    else $error("write strobe before flag settle time");
  a_token_chip_high: assert property (!tsel_n_reg |-> ce_n_reg)
    else $error("chip select low during token access");
  a_token_lanes_high: assert property (
    !tsel_n_reg |-> ub_n_reg && lb_n_reg)
    else $error("lane select low during token access");
  a_token_addr_low: assert property (
    !tsel_n_reg |-> addr_reg[ADDR_W-1:TOKEN_AW] == '0)
    else $error("token access with high address bits set");
  a_token_data_bit: assert property (
    !tsel_n_reg && doe_reg |-> dout_reg[DATA_W-1:1] == '0)
    else $error("token write drives more than bit zero");
  a_recovery_gap_held: assert property (
    $rose(tsel_n_reg) |-> (tsel_n_reg && oe_n_reg) [*2])
    else $error("token recovery gap too short");
  a_acquire_write_zero: assert property (
    is_acq && !tsel_n_reg && !rw_n_reg |-> dout_reg[0] == 1'b0)
    else $error("acquire wrote a one to the token");
  a_acquire_readback: assert property (
    is_acq && $rose(rw_n_reg) && tsel_n_reg |-> ##[1:8] !oe_n_reg)
    else $error("acquire did not read back the token");

  c_token_owned: cover property (
    is_acq && $rose(owned_reg));
  c_contention_wait: cover property (
    $rose(cont_reg));
  c_memory_read: cover property (
    !ce_n_reg && !oe_n_reg);

endmodule

// file: dpt_host_ctrl_bench.sv
// Self-checking bench for the token mailbox host controller
`timescale 1ns/1ps
module dpt_host_ctrl_bench
  import dpt_pkg::*;
;
  logic              sys_clk, rstn, sw_wr, sw_rd, force_busy;
  logic [REG_AW-1:0] sw_addr;
  logic [31:0]       sw_wdata, sw_rdata, rv;
  logic              ce_n, rw_n, oe_n, tsn, uls_n, lls_n;
  logic              data_oe, busy_n, int_n;
  logic [ADDR_W-1:0] mem_addr;
  logic [DATA_W-1:0] data_in, data_out;
  int                errors, checks_done, cyc;

  dpt_host_ctrl i_dut (.sys_clk(sys_clk), .rstn(rstn), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .ce_n(ce_n), .rw_n(rw_n), .oe_n(oe_n), .token_select_n(tsn),
    .upper_lane_select_n(uls_n), .lower_lane_select_n(lls_n),
    .mem_addr(mem_addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .busy_n(busy_n), .int_n(int_n));
  dpt_dev_model i_mdl (.sys_clk(sys_clk), .ce_n(ce_n), .rw_n(rw_n),
    .oe_n(oe_n), .token_select_n(tsn), .upper_lane_select_n(uls_n),
    .lower_lane_select_n(lls_n), .mem_addr(mem_addr), .data_out(data_out),
    .data_oe(data_oe), .data_in(data_in), .force_busy(force_busy),
    .busy_n(busy_n), .int_n(int_n), .int_r_n());

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Verdict and end of run
  task automatic stop_test();
    if (errors == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      errors++;
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask

  // Register read; data stands only in the cycle after the strobe
  task automatic rd(input logic [REG_AW-1:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    @(negedge sys_clk);
    d = sw_rdata;
  endtask

  // Start one access: address, data, then control
  task automatic acc(input logic [2:0] op, input logic lo, input logic up,
                     input logic [12:0] a, input logic [31:0] d);
    wr(REG_ADDR, {19'h0, a});
    wr(REG_WDATA, d);
    wr(REG_CTRL, {24'h0, 2'b00, lo, up, 1'b0, op});
  endtask

  // Poll the busy bit under a bounded count
  task automatic idle();
    for (int k = 0; k < 100; k++) begin
      rd(REG_STATUS, rv);
      if (rv[0] === 1'b0) break;
    end
    chk(rv[0], 1'b0);
  endtask

  // Hang guard; the full sequence needs about 400 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      stop_test();
    end
  end

  initial begin
    {rstn, sw_wr, sw_rd, force_busy, sw_addr, sw_wdata} = '0;
    {errors, checks_done, cyc} = '0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    rd(REG_STATUS, rv);
    chk(rv, 32'h0);
    rd(3'h5, rv);
    chk(rv, 32'h0);
    // Byte lanes on write and read
    acc(OP_MEM_WR, 1'b1, 1'b1, 13'h1FFF, 32'h1234A5C3);
    idle();
    chk(i_mdl.mem[13'h1FFF], 32'hA5C3);
    chk(i_mdl.int_r_n, 1'b0);
    acc(OP_MEM_WR, 1'b1, 1'b1, 13'h0010, 32'h1111);
    idle();
    acc(OP_MEM_WR, 1'b0, 1'b1, 13'h0010, 32'hEEEE);
    idle();
    chk(i_mdl.mem[13'h0010], 32'hEE11);
    acc(OP_MEM_RD, 1'b0, 1'b1, 13'h0010, 32'h0);
    idle();
    rd(REG_RDATA, rv);
    chk(rv[15:8], 32'hEE);
    // Control readback keeps the upper-only lane choice
    rd(REG_CTRL, rv);
    chk(rv, 32'h11);
    // Mailbox interrupt: other mailbox read keeps it, own read clears it
    i_mdl.right_mbox(16'h0042);
    rd(REG_STATUS, rv);
    chk(rv[2], 1'b1);
    acc(OP_MEM_RD, 1'b1, 1'b1, 13'h1FFF, 32'h0);
    idle();
    chk(int_n, 1'b0);
    acc(OP_MEM_RD, 1'b1, 1'b1, 13'h1FFE, 32'h0);
    idle();
    chk(int_n, 1'b1);
    rd(REG_RDATA, rv);
    chk(rv, 32'h42);
    // Contention holds the write back until the flag settles
    @(posedge sys_clk) force_busy <= 1'b1;
    acc(OP_MEM_WR, 1'b1, 1'b1, 13'h0020, 32'h5555);
    repeat (20) @(posedge sys_clk);
    rd(REG_STATUS, rv);
    chk(rv[3:0], 32'h9);
    @(posedge sys_clk) force_busy <= 1'b0;
    idle();
    chk(i_mdl.mem[13'h0020], 32'h5555);
    wr(REG_STATUS, 32'h8);
    rd(REG_STATUS, rv);
    chk(rv, 32'h0);
    // Acquire a free token through a high address
    acc(OP_TOK_ACQ, 1'b0, 1'b0, 13'h1FFB, 32'h0);
    idle();
    rd(REG_STATUS, rv);
    chk(rv[1], 1'b1);
    chk(i_mdl.own[3], 2'd1);
    // Address register keeps every bit; only the pins are cut to three
    rd(REG_ADDR, rv);
    chk(rv, 32'h1FFB);
    // Token held by the right port; only bit zero is written
    i_mdl.tok_write(5, 2'd2, 1'b0);
    acc(OP_TOK_WR, 1'b0, 1'b0, 13'h0005, 32'hFFFE);
    idle();
    chk(i_mdl.req[1][5], 1'b1);
    acc(OP_TOK_RD, 1'b0, 1'b0, 13'h0005, 32'h0);
    idle();
    rd(REG_RDATA, rv);
    chk(rv, 32'hFFFF);
    i_mdl.tok_write(5, 2'd2, 1'b1);
    acc(OP_TOK_RD, 1'b0, 1'b0, 13'h0005, 32'h0);
    idle();
    rd(REG_RDATA, rv);
    chk(rv, 32'h0);
    acc(OP_TOK_WR, 1'b0, 1'b0, 13'h0005, 32'h1);
    idle();
    chk(i_mdl.own[5], 2'd0);
    // Acquire keeps polling a held token until aborted
    i_mdl.tok_write(6, 2'd2, 1'b0);
    acc(OP_TOK_ACQ, 1'b0, 1'b0, 13'h0006, 32'h0);
    repeat (40) @(posedge sys_clk);
    rd(REG_STATUS, rv);
    chk(rv[1:0], 32'h1);
    wr(REG_CTRL, 32'h80);
    idle();
    chk(i_mdl.own[6], 2'd2);
    // Codes above acquire must start nothing
    wr(REG_CTRL, 32'h7);
    rd(REG_STATUS, rv);
    chk(rv, 32'h0);
    // Reset in mid-access leaves the port deselected and idle
    acc(OP_MEM_RD, 1'b1, 1'b1, 13'h0010, 32'h0);
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b0;
    @(posedge sys_clk) rstn <= 1'b1;
    chk({ce_n, rw_n, oe_n, tsn, uls_n, lls_n, data_oe}, 32'h7E);
    rd(REG_STATUS, rv);
    chk(rv, 32'h0);
    stop_test();
  end
endmodule

// file: dpt_pkg.sv
// Constants and types for the dual-port token mailbox host controller
package dpt_pkg;

  // Pin widths of the memory port, counter and register address widths
  localparam int ADDR_W   = 13;
  localparam int DATA_W   = 16;
  localparam int TOKEN_AW = 3;
  localparam int CNT_W    = 8;
  localparam int REG_AW   = 3;

  // Timing in ns; pin timing is not fixed, plain defaults
  localparam int CLK_PERIOD_NS         = 5;
  localparam int FLAG_SETTLE_NS        = 15;
  localparam int ACCESS_TIME_NS        = 25;
  localparam int TOKEN_RECOVERY_GAP_NS = 10;

  // Least times rounded up to whole clock cycles
  localparam logic [CNT_W-1:0] SETTLE_CYC =
    CNT_W'((FLAG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] ACCESS_CYC =
    CNT_W'((ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] GAP_CYC =
    CNT_W'((TOKEN_RECOVERY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_LAST = 8'h01;

  // Software register indices
  localparam logic [REG_AW-1:0] REG_CTRL   = 3'h0;
  localparam logic [REG_AW-1:0] REG_ADDR   = 3'h1;
  localparam logic [REG_AW-1:0] REG_WDATA  = 3'h2;
  localparam logic [REG_AW-1:0] REG_RDATA  = 3'h3;
  localparam logic [REG_AW-1:0] REG_STATUS = 3'h4;

  // Control register fields
  localparam int CTRL_OP_LSB    = 0;
  localparam int CTRL_OP_MSB    = 2;
  localparam int CTRL_UPPER_BIT = 4;
  localparam int CTRL_LOWER_BIT = 5;
  localparam int CTRL_ABORT_BIT = 7;

  // Operation codes
  localparam logic [2:0] OP_MEM_WR  = 3'h0;
  localparam logic [2:0] OP_MEM_RD  = 3'h1;
  localparam logic [2:0] OP_TOK_WR  = 3'h2;
  localparam logic [2:0] OP_TOK_RD  = 3'h3;
  localparam logic [2:0] OP_TOK_ACQ = 3'h4;

  // Status register fields
  localparam int ST_BUSY_BIT       = 0;
  localparam int ST_OWNED_BIT      = 1;
  localparam int ST_INT_BIT        = 2;
  localparam int ST_CONTENTION_BIT = 3;

  // Reset pin levels; between accesses address and data keep their last values
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // Access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_RECOVER
  } dpt_state_t;

endpackage
